// [rtl/apc_pkg.sv]
/*
  apc_pkg: constants, register map, field layout and carrier types for the
  converter's digital control and parallel output block.
  Assumes: one system clock domain; the sample clock is sampled, not used as a clock.
*/
package apc_pkg;

  // ------------------------------------------------------------
  // sizes and cycle counts (counts are sample clock cycles)
  // ------------------------------------------------------------
  localparam int DATA_W = 10;
  localparam int PIPE_LAT_CYC = 12;
  localparam int PD_STARTUP_CYC = 900;
  localparam int SLP_STARTUP_CYC = 20;
  localparam int OVR_RECOVERY_CYC = 1;
  localparam int WAKE_CNT_W = 10;
  localparam logic [WAKE_CNT_W-1:0] PD_WAKE_LAST = WAKE_CNT_W'(PD_STARTUP_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] SLP_WAKE_LAST = WAKE_CNT_W'(SLP_STARTUP_CYC - 1);

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LAST_SAMPLE = 8'h0c;

  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BIAS_LSB = 4;
  localparam int ST_FMT_BIT = 6;
  localparam int ST_OE_BIT = 7;
  localparam int ST_CLK_OE_BIT = 8;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_READY = 0;
  localparam int IRQ_RANGE = 1;
  localparam int IRQ_PWRDN = 2;
  localparam int IRQ_SLEEP = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    APC_PWRDN,
    APC_PD_WAKE,
    APC_SLEEP,
    APC_SLP_WAKE,
    APC_ACTIVE
  } apc_state_e;

  typedef enum logic [1:0] {
    APC_BIAS_OFF,
    APC_BIAS_50UA,
    APC_BIAS_500UA,
    APC_BIAS_1MA
  } apc_bias_e;

  typedef struct packed {
    logic power_down_low;
    logic sleep_request_low;
    logic number_format_select;
    logic fwd_clock_drive_enable_low;
    logic output_enable_low;
    logic cm_buffer_bias_hi;
    logic cm_buffer_bias_lo;
  } apc_pins_s;

  typedef struct packed {
    logic range_exceeded_flag;
    logic [DATA_W-1:0] code;
  } apc_sample_s;

  localparam int PINS_W = $bits(apc_pins_s);
  localparam int SAMPLE_W = $bits(apc_sample_s);

endpackage : apc_pkg

// [rtl/apc_sync2.sv]
/*
  apc_sync2: two-flop synchroniser, one chain per bit.
  Assumes: inputs are asynchronous levels; clock enable freezes the chain.
*/
`timescale 1ns/1ps
`default_nettype none

module apc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // the first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else if (ce) begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end

endmodule : apc_sync2

`default_nettype wire

// [rtl/apc_top.sv]
/*
  apc_top: digital control and parallel output of a 10-bit sampling converter.
  Mode control from static pins, output pipeline, format, tristate enables,
  bias decode, forwarded clock, status registers and interrupt.
  Assumes: the sample clock and all pins are asynchronous to clk_sys and the
  sample clock runs at most a quarter of clk_sys; core words are stable
  for most of a sample period.
*/
// Notes on behaviour
// - forwarded clock driven while its enable pin is low, tristate when high
// - format pin 0 gives offset binary, 1 gives two's complement
// - power-down pin low enters full power-down; high resumes conversion
// - in power-down the output word and forwarded clock read zero
// - data outputs tristate while output enable pin high, driven while low
// - range flag high for each out-of-range sample, low otherwise
// - output word is parallel, bit 0 least, bit 9 most significant
// - bias pins: 00 off, 01 50 uA, 10 500 uA, 11 1 mA
// - forwarded clock is aligned with data for capture
// - valid samples within 900 sample cycles after power-down ends
// - sleep while sleep pin low; valid within 20 cycles after it rises
// - correct results about one cycle after out-of-range input ends
// - only the rising edge of the sample clock times activity
`timescale 1ns/1ps
`default_nettype none

module apc_top (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // sample clock pins
  input wire logic sample_clock_pos,
  input wire logic sample_clock_neg,
  // static control pins
  input wire apc_pkg::apc_pins_s pins,
  // converter core result
  input wire apc_pkg::apc_sample_s core_sample,
  // parallel output
  output var apc_pkg::apc_sample_s sample_out,
  output logic sample_out_oe,
  output logic forwarded_sample_clock,
  output logic forwarded_clock_oe,
  // common-mode buffer
  output logic cm_buffer_enable,
  output var apc_pkg::apc_bias_e cm_bias,
  // register port
  input wire logic [apc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  localparam int SYNC_W = apc_pkg::PINS_W + apc_pkg::SAMPLE_W + 2;

  logic [SYNC_W-1:0] sync_q;
  apc_pkg::apc_pins_s pins_s;
  apc_pkg::apc_sample_s core_s;
  logic clk_pos_s;
  logic clk_neg_s;
  logic clk_level;
  logic clk_level_d;
  logic samp_rise;

  // a word may tear across bits only if the core changes it near our edge
  apc_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .d({pins, core_sample, sample_clock_pos, sample_clock_neg}),
    .q(sync_q)
  );

  assign {pins_s, core_s, clk_pos_s, clk_neg_s} = sync_q;
  assign clk_level = clk_pos_s & ~clk_neg_s;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_level_d <= 1'b0;
    end else if (ce) begin
      clk_level_d <= clk_level;
    end
  end

  // falling edges are deliberately ignored
  assign samp_rise = clk_level & ~clk_level_d;

  // ------------------------------------------------------------
  // mode control
  // ------------------------------------------------------------
  apc_pkg::apc_state_e state;
  apc_pkg::apc_state_e next_state;
  logic [apc_pkg::WAKE_CNT_W-1:0] wake_cnt;

  always_comb begin
    next_state = state;
    if (!pins_s.power_down_low) begin
      next_state = apc_pkg::APC_PWRDN;
    end else begin
      case (state)
        apc_pkg::APC_PWRDN: begin
          next_state = apc_pkg::APC_PD_WAKE;
        end
        apc_pkg::APC_PD_WAKE: begin
          if (!pins_s.sleep_request_low) begin
            next_state = apc_pkg::APC_SLEEP;
          end else if (samp_rise && wake_cnt == apc_pkg::PD_WAKE_LAST) begin
            next_state = apc_pkg::APC_ACTIVE;
          end
        end
        apc_pkg::APC_SLEEP: begin
          if (pins_s.sleep_request_low) begin
            next_state = apc_pkg::APC_SLP_WAKE;
          end
        end
        apc_pkg::APC_SLP_WAKE: begin
          if (!pins_s.sleep_request_low) begin
            next_state = apc_pkg::APC_SLEEP;
          end else if (samp_rise && wake_cnt == apc_pkg::SLP_WAKE_LAST) begin
            next_state = apc_pkg::APC_ACTIVE;
          end
        end
        apc_pkg::APC_ACTIVE: begin
          if (!pins_s.sleep_request_low) begin
            next_state = apc_pkg::APC_SLEEP;
          end
        end
        default: begin
          next_state = apc_pkg::APC_PWRDN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= apc_pkg::APC_PWRDN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // wake counter counts sample clock rising edges
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_cnt <= '0;
    end else if (ce) begin
      if (next_state != state) begin
        wake_cnt <= '0;
      end else if (samp_rise) begin
        wake_cnt <= wake_cnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // sample pipeline
  // ------------------------------------------------------------
  localparam int STAGES = apc_pkg::PIPE_LAT_CYC - 1;

  apc_pkg::apc_sample_s pipe [STAGES];
  apc_pkg::apc_sample_s tail;

  // output register is the last of the twelve stages
  for (genvar i = 0; i < STAGES; i++) begin : g_pipe
    always_ff @(posedge clk_sys) begin
      if (!rst_n || (ce && !pins_s.power_down_low)) begin
        pipe[i] <= '0;
      end else if (ce && samp_rise) begin
        if (i == 0) begin
          pipe[i] <= core_s;
        end else begin
          pipe[i] <= pipe[(i == 0) ? 0 : i - 1];
        end
      end
    end
  end

  assign tail = pipe[STAGES-1];

  // ------------------------------------------------------------
  // parallel output
  // ------------------------------------------------------------
  logic [apc_pkg::DATA_W-1:0] fmt_flip;

  // two's complement is offset binary with the top bit inverted
  assign fmt_flip = {pins_s.number_format_select, {(apc_pkg::DATA_W-1){1'b0}}};

  always_ff @(posedge clk_sys) begin
    if (!rst_n || (ce && !pins_s.power_down_low)) begin
      sample_out <= '0;
    end else if (ce && samp_rise) begin
      if (state == apc_pkg::APC_ACTIVE) begin
        // each flag travels with its own word, so recovery is immediate
        sample_out.range_exceeded_flag <= tail.range_exceeded_flag;
        sample_out.code <= tail.code ^ fmt_flip;
      end else begin
        sample_out <= '0;
      end
    end
  end

  // rises only with a word update, so a mid-phase mode change cannot fake a word
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (ce && !pins_s.power_down_low)) begin
      forwarded_sample_clock <= 1'b0;
    end else if (ce) begin
      forwarded_sample_clock <= samp_rise ? (state == apc_pkg::APC_ACTIVE)
        : (forwarded_sample_clock & clk_level);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sample_out_oe <= 1'b0;
      forwarded_clock_oe <= 1'b0;
    end else if (ce) begin
      sample_out_oe <= ~pins_s.output_enable_low;
      forwarded_clock_oe <= ~pins_s.fwd_clock_drive_enable_low;
    end
  end

  // ------------------------------------------------------------
  // common-mode buffer bias
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cm_bias <= apc_pkg::APC_BIAS_OFF;
      cm_buffer_enable <= 1'b0;
    end else if (ce) begin
      cm_bias <= apc_pkg::apc_bias_e'({pins_s.cm_buffer_bias_hi, pins_s.cm_buffer_bias_lo});
      cm_buffer_enable <= pins_s.cm_buffer_bias_hi | pins_s.cm_buffer_bias_lo;
    end
  end

  // ------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------
  logic [apc_pkg::IRQ_W-1:0] irq_stat;
  logic [apc_pkg::IRQ_W-1:0] irq_mask;
  logic [apc_pkg::IRQ_W-1:0] events;
  logic [apc_pkg::IRQ_W-1:0] irq_clr;
  logic wr_stat;

  always_comb begin
    events = '0;
    events[apc_pkg::IRQ_READY] = (state != apc_pkg::APC_ACTIVE)
      && (next_state == apc_pkg::APC_ACTIVE);
    events[apc_pkg::IRQ_RANGE] = samp_rise && (state == apc_pkg::APC_ACTIVE)
      && tail.range_exceeded_flag;
    events[apc_pkg::IRQ_PWRDN] = (state != apc_pkg::APC_PWRDN)
      && (next_state == apc_pkg::APC_PWRDN);
    events[apc_pkg::IRQ_SLEEP] = (state != apc_pkg::APC_SLEEP)
      && (next_state == apc_pkg::APC_SLEEP);
  end

  assign wr_stat = reg_wr && (reg_addr == apc_pkg::REG_IRQ_STAT);
  assign irq_clr = wr_stat ? reg_wdata[apc_pkg::IRQ_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_stat <= apc_pkg::IRQ_STAT_RST;
    end else if (ce) begin
      irq_stat <= (irq_stat & ~irq_clr) | events;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_mask <= apc_pkg::IRQ_MASK_RST;
    end else if (ce && reg_wr && reg_addr == apc_pkg::REG_IRQ_MASK) begin
      irq_mask <= reg_wdata[apc_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[apc_pkg::ST_MODE_LSB +: 3] = state;
    status_word[apc_pkg::ST_BIAS_LSB +: 2] = cm_bias;
    status_word[apc_pkg::ST_FMT_BIT] = pins_s.number_format_select;
    status_word[apc_pkg::ST_OE_BIT] = sample_out_oe;
    status_word[apc_pkg::ST_CLK_OE_BIT] = forwarded_clock_oe;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      if (!reg_rd) begin
        reg_rdata <= '0;
      end else if (reg_addr == apc_pkg::REG_STATUS) begin
        reg_rdata <= status_word;
      end else if (reg_addr == apc_pkg::REG_IRQ_STAT) begin
        reg_rdata <= {{(32-apc_pkg::IRQ_W){1'b0}}, irq_stat};
      end else if (reg_addr == apc_pkg::REG_IRQ_MASK) begin
        reg_rdata <= {{(32-apc_pkg::IRQ_W){1'b0}}, irq_mask};
      end else if (reg_addr == apc_pkg::REG_LAST_SAMPLE) begin
        reg_rdata <= {{(32-apc_pkg::SAMPLE_W){1'b0}}, sample_out};
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pd_outputs_zero_a: assert property (
    (state == apc_pkg::APC_PWRDN) |-> (sample_out == '0) && !forwarded_sample_clock
  ) else $error("output not zero in power-down");
  pd_entry_a: assert property (
    (ce && !pins_s.power_down_low) |=> (state == apc_pkg::APC_PWRDN)
  ) else $error("power-down pin low did not enter power-down");
  pd_wake_done_a: assert property (
    (ce && state == apc_pkg::APC_PD_WAKE && samp_rise && wake_cnt == apc_pkg::PD_WAKE_LAST
      && pins_s.power_down_low && pins_s.sleep_request_low) |=> (state == apc_pkg::APC_ACTIVE)
  ) else $error("power-down wake not done in time");
  slp_wake_done_a: assert property (
    (ce && state == apc_pkg::APC_SLP_WAKE && samp_rise && wake_cnt == apc_pkg::SLP_WAKE_LAST
      && pins_s.power_down_low && pins_s.sleep_request_low) |=> (state == apc_pkg::APC_ACTIVE)
  ) else $error("sleep wake not done in time");
  word_format_a: assert property (
    (ce && samp_rise && state == apc_pkg::APC_ACTIVE && pins_s.power_down_low)
      |=> sample_out.code == ($past(tail.code) ^ {$past(pins_s.number_format_select), 9'h000})
  ) else $error("output word format wrong");
  range_flag_a: assert property (
    (ce && samp_rise && state == apc_pkg::APC_ACTIVE && pins_s.power_down_low)
      |=> sample_out.range_exceeded_flag == $past(tail.range_exceeded_flag)
  ) else $error("range flag not carried with word");
  rise_only_a: assert property (
    (ce && !samp_rise && pins_s.power_down_low) |=> $stable(sample_out)
  ) else $error("output changed without a rising edge");
  data_oe_a: assert property (
    ce |=> sample_out_oe == !$past(pins_s.output_enable_low)
  ) else $error("data output enable wrong");
  clk_oe_a: assert property (
    ce |=> forwarded_clock_oe == !$past(pins_s.fwd_clock_drive_enable_low)
  ) else $error("forwarded clock enable wrong");
  bias_decode_a: assert property (
    cm_buffer_enable == (cm_bias != apc_pkg::APC_BIAS_OFF)
  ) else $error("buffer enable disagrees with bias code");

endmodule : apc_top

`default_nettype wire

// [tb/apc_capture_model.sv]
/*
  apc_capture_model: receiving logic that latches output words on the forwarded clock.
  Assumes: apc_top outputs are sampled on clk_sys; a released bus is never captured.
*/
`timescale 1ns/1ps
`default_nettype none

module apc_capture_model (
  // clock
  input wire logic clk_sys,
  // device outputs
  input wire apc_pkg::apc_sample_s sample_out,
  input wire logic sample_out_oe,
  input wire logic forwarded_sample_clock,
  input wire logic forwarded_clock_oe,
  // captured word
  output var apc_pkg::apc_sample_s cap_word,
  output logic cap_valid,
  output var int cap_count
);
  logic fwd_prev = 1'b0;

  initial begin
    cap_word = '0;
    cap_valid = 1'b0;
    cap_count = 0;
  end

  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  // word and flag taken together, only while both drivers are on
  always @(posedge clk_sys) begin
    fwd_prev <= forwarded_sample_clock & forwarded_clock_oe;
    cap_valid <= 1'b0;
    if (forwarded_sample_clock && forwarded_clock_oe && !fwd_prev && sample_out_oe) begin
      cap_word <= sample_out;
      cap_valid <= 1'b1;
      cap_count <= cap_count + 1;
    end
  end
endmodule : apc_capture_model

`default_nettype wire

// [tb/tb_adc_parallel_output_control.sv]
/*
  tb_adc_parallel_output_control: self-checking bench for apc_top.
  Assumes: apc_pkg and apc_capture_model compiled first; ce held high, single-ended clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_adc_parallel_output_control;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sample_clock_pos = 1'b0;
  apc_pkg::apc_pins_s pins = 7'h23;
  apc_pkg::apc_sample_s core_sample = '0;
  apc_pkg::apc_sample_s sample_out;
  apc_pkg::apc_sample_s cap_word;
  apc_pkg::apc_bias_e cm_bias;
  logic sample_out_oe, forwarded_sample_clock, forwarded_clock_oe, cm_buffer_enable, irq;
  logic cap_valid;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] phase = 3'h0;
  logic [9:0] samp_idx = 10'h000;
  logic [9:0] raw;
  logic [9:0] lag;
  logic stream_on = 1'b0;
  int cap_count;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  int c0;

  apc_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .sample_clock_pos(sample_clock_pos), .sample_clock_neg(1'b0),
    .pins(pins), .core_sample(core_sample), .sample_out(sample_out),
    .sample_out_oe(sample_out_oe), .forwarded_sample_clock(forwarded_sample_clock),
    .forwarded_clock_oe(forwarded_clock_oe), .cm_buffer_enable(cm_buffer_enable),
    .cm_bias(cm_bias), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  apc_capture_model capt (
    .clk_sys(clk_sys), .sample_out(sample_out), .sample_out_oe(sample_out_oe),
    .forwarded_sample_clock(forwarded_sample_clock), .forwarded_clock_oe(forwarded_clock_oe),
    .cap_word(cap_word), .cap_valid(cap_valid), .cap_count(cap_count)
  );

  // ------------------------------------------------------------
  // clocks and stimulus
  // ------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;

  // 320 ns sample clock; core word counts samples, changed mid-period so it is stable
  always @(posedge clk_sys) begin
    phase <= phase + 3'h1;
    if (phase == 3'h3) begin
      sample_clock_pos <= 1'b1;
      samp_idx <= samp_idx + 10'h001;
    end
    if (phase == 3'h7) begin
      sample_clock_pos <= 1'b0;
      core_sample <= {samp_idx[2:0] == 3'h3, samp_idx};
    end
  end

  // run needs about 8400 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_val = reg_rdata;
    @(posedge clk_sys);
  endtask : rd

  task automatic edges(input int k);
    repeat (k) @(posedge sample_clock_pos);
    @(posedge clk_sys);
  endtask : edges

  // poll the mode field once per sample edge; n ends as edges waited
  task automatic wait_mode(input logic [2:0] mode, input int limit);
    n = 0;
    rd_val = 32'hffffffff;
    while (rd_val[2:0] !== mode && n <= limit) begin
      edges(1);
      n = n + 1;
      rd(apc_pkg::REG_STATUS);
    end
  endtask : wait_mode

  task automatic end_of_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // stream checks
  // ------------------------------------------------------------
  // lag of 12 or 13 edges covers where the core capture edge is counted
  always @(posedge clk_sys) begin
    if (cap_valid && stream_on) begin
      raw = cap_word.code ^ {pins.number_format_select, 9'h000};
      lag = samp_idx - raw;
      chk(32'(lag >= 10'h00c && lag <= 10'h00d), 32'h1);
      chk(32'(cap_word.range_exceeded_flag), 32'(raw[2:0] == 3'h3));
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(apc_pkg::REG_STATUS);
    chk(rd_val, 32'h1b0);
    chk(32'(sample_out), 32'h0);
    chk(forwarded_sample_clock, 32'h0);
    $display("test reset done");

    wr(apc_pkg::REG_IRQ_MASK, 32'hf);
    rd(apc_pkg::REG_IRQ_MASK);
    chk(rd_val, 32'hf);
    wr(apc_pkg::REG_IRQ_STAT, 32'hf);
    rd(apc_pkg::REG_IRQ_STAT);
    chk(rd_val, 32'h0);
    chk(irq, 32'h0);
    rd(8'h10);
    chk(rd_val, 32'h0);
    wr(apc_pkg::REG_STATUS, 32'hffffffff);
    rd(apc_pkg::REG_STATUS);
    chk(rd_val, 32'h1b0);
    $display("test registers done");

    // power-down held since start serves as the reset pulse
    pins.power_down_low <= 1'b1;
    wait_mode(3'h4, 901);
    chk(32'(n <= 901), 32'h1);
    rd(apc_pkg::REG_IRQ_STAT);
    chk(rd_val[apc_pkg::IRQ_READY], 32'h1);
    chk(irq, 32'h1);
    stream_on <= 1'b1;
    c0 = cap_count;
    edges(40);
    repeat (4) @(posedge clk_sys);
    chk(32'(cap_count - c0), 32'h28);
    rd(apc_pkg::REG_IRQ_STAT);
    chk(rd_val[apc_pkg::IRQ_RANGE], 32'h1);
    $display("test wake and stream done");

    stream_on <= 1'b0;
    pins.number_format_select <= 1'b1;
    edges(16);
    stream_on <= 1'b1;
    edges(24);
    rd(apc_pkg::REG_STATUS);
    chk(rd_val[apc_pkg::ST_FMT_BIT], 32'h1);
    stream_on <= 1'b0;
    pins.number_format_select <= 1'b0;
    edges(16);
    stream_on <= 1'b1;
    $display("test format done");

    pins.output_enable_low <= 1'b1;
    pins.fwd_clock_drive_enable_low <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(sample_out_oe, 32'h0);
    chk(forwarded_clock_oe, 32'h0);
    pins.output_enable_low <= 1'b0;
    pins.fwd_clock_drive_enable_low <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk(sample_out_oe, 32'h1);
    chk(forwarded_clock_oe, 32'h1);
    for (int b = 0; b < 4; b++) begin
      {pins.cm_buffer_bias_hi, pins.cm_buffer_bias_lo} <= 2'(b);
      repeat (5) @(posedge clk_sys);
      chk(32'(cm_bias), 32'(b));
      chk(32'(cm_buffer_enable), 32'(b != 0));
    end
    $display("test enables and bias done");

    pins.sleep_request_low <= 1'b0;
    edges(4);
    rd(apc_pkg::REG_STATUS);
    chk(rd_val[2:0], 32'h2);
    chk(32'(sample_out), 32'h0);
    chk(forwarded_sample_clock, 32'h0);
    pins.sleep_request_low <= 1'b1;
    wait_mode(3'h4, 21);
    chk(32'(n <= 21), 32'h1);
    edges(8);
    rd(apc_pkg::REG_IRQ_STAT);
    chk(rd_val[apc_pkg::IRQ_SLEEP], 32'h1);
    $display("test sleep done");

    pins.power_down_low <= 1'b0;
    repeat (6) @(posedge clk_sys);
    repeat (12) begin
      @(posedge clk_sys);
      chk(32'(sample_out), 32'h0);
      chk(forwarded_sample_clock, 32'h0);
    end
    rd(apc_pkg::REG_STATUS);
    chk(rd_val[2:0], 32'h0);
    rd(apc_pkg::REG_LAST_SAMPLE);
    chk(rd_val, 32'h0);
    rd(apc_pkg::REG_IRQ_STAT);
    chk(rd_val[apc_pkg::IRQ_PWRDN], 32'h1);
    $display("test power-down done");
    end_of_test();
  end
endmodule : tb_adc_parallel_output_control

`default_nettype wire
